// *** acs_sequencer.sv ***
/*
 * Converter configuration sequencer: mux decode, sequence memory, entry
 * pointer, programming window and the serial data/flag output.
 * Assumes conv_busy and conv_result come from the converter core on aclk,
 * while serial_clock and serial_in are pins from the host, sampled here.
 */
// The implementer's own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
module acs_sequencer
    import acs_pkg::*;
#(
    parameter int SEQ_DEPTH = 16
) (
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic [ACS_ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [ACS_ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    input  wire logic                    serial_clock,
    input  wire logic                    serial_in,
    output logic                         serial_out,
    input  wire logic                    conv_busy,
    input  wire logic [ACS_RESULT_W-1:0] conv_result,
    output logic [ACS_SEL_W-1:0]         mux_output_pos,
    output logic [ACS_SEL_W-1:0]         mux_output_neg,
    output logic [1:0]                   range_sel,
    output logic                         gain_comp_sel,
    output logic                         acquire_restart,
    output logic                         sequence_head_flag
);
    localparam int IDX_W = $clog2(SEQ_DEPTH);

    // Pin synchronisers and edge history.
    logic [2:0] sck_sync;
    logic [1:0] sdi_sync;
    logic       busy_q;
    // Sequence state.
    logic [ACS_CFG_W-1:0] mem [SEQ_DEPTH];
    logic [IDX_W:0]       depth;
    logic [IDX_W-1:0]     active_idx;
    logic [IDX_W-1:0]     used_idx;
    logic [IDX_W:0]       written;
    acs_win_t             win;
    logic [2:0]           bit_cnt;
    logic [ACS_CFG_W-1:0] shift_in;
    logic [ACS_FRAME_W-1:0] shift_out;
    logic [4:0]           out_cnt;
    logic                 port_en;
    // Bus state.
    logic                 aw_got;
    logic                 w_got;
    logic [ACS_ADDR_W-1:0] aw_addr;
    logic [31:0]          w_data;
    logic [3:0]           w_strb;

    // Edge detection uses only the second and third synchroniser stages.
    wire sck_rise   = sck_sync[1] & ~sck_sync[2];
    wire sdi_bit    = sdi_sync[1];
    wire busy_rise  = conv_busy & ~busy_q;
    wire busy_fall  = ~conv_busy & busy_q;
    wire bit_take   = sck_rise & port_en & ~conv_busy & (win == ACS_WIN_OPEN);
    wire msb_zero   = bit_take & (bit_cnt == 3'h0) & ~sdi_bit;
    wire word_done  = bit_take & (bit_cnt == 3'h7);
    wire first_word = word_done & (written == '0);
    wire mem_full   = word_done & (written == (IDX_W+1)'(SEQ_DEPTH - 1));
    wire [ACS_WORD_W-1:0] word_in = {shift_in, sdi_bit};
    wire [IDX_W-1:0] last_idx = IDX_W'(depth - 1'b1);
    wire [IDX_W-1:0] next_active = (active_idx == last_idx) ? '0 : active_idx + 1'b1;

    // Mux decode of the entry now applied.
    wire [ACS_CFG_W-1:0] cur_cfg = mem[active_idx];
    wire [3:0] mux_code = cur_cfg[ACS_MUX_HI:ACS_MUX_LO];
    wire [3:0] pos_idx  = mux_code[3] ? {1'b0, mux_code[2:0]}
                                      : {1'b0, mux_code[1:0], mux_code[2]};
    wire [3:0] neg_idx  = mux_code[3] ? ACS_COM_IDX
                                      : {1'b0, mux_code[1:0], ~mux_code[2]};
    wire [ACS_SEL_W-1:0] next_pos = ACS_SEL_W'(1) << pos_idx;
    wire [ACS_SEL_W-1:0] next_neg = ACS_SEL_W'(1) << neg_idx;

    // Synchronise the serial pins and remember the busy level.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sck_sync <= 3'h0;
            sdi_sync <= 2'h0;
            busy_q   <= 1'b0;
        end else begin
            sck_sync <= {sck_sync[1:0], serial_clock};
            sdi_sync <= {sdi_sync[0], serial_in};
            busy_q   <= conv_busy;
        end
    end

    // Programming window and word assembly.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            win      <= ACS_WIN_OPEN;
            bit_cnt  <= 3'h0;
            shift_in <= '0;
            written  <= '0;
        end else if (busy_fall) begin
            win      <= ACS_WIN_OPEN;
            bit_cnt  <= 3'h0;
            written  <= '0;
        end else if (busy_rise || msb_zero || mem_full) begin
            win      <= ACS_WIN_CLOSED;
            bit_cnt  <= 3'h0;
        end else if (bit_take) begin
            bit_cnt  <= bit_cnt + 3'h1;
            shift_in <= {shift_in[ACS_CFG_W-2:0], sdi_bit};
            if (word_done) begin
                written <= written + 1'b1;
            end
        end
    end

    // Sequence memory, depth and pointer.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < SEQ_DEPTH; i++) begin
                mem[i] <= ACS_CFG_RESET;
            end
            depth      <= (IDX_W+1)'(1);
            active_idx <= '0;
            used_idx   <= '0;
        end else if (word_done) begin
            if (first_word) begin
                for (int i = 1; i < SEQ_DEPTH; i++) begin
                    mem[i] <= ACS_CFG_RESET;
                end
                active_idx <= '0;
            end
            mem[IDX_W'(written)] <= word_in[ACS_CFG_W-1:0];
            depth <= written + 1'b1;
        end else if (busy_rise) begin
            used_idx   <= active_idx;
            active_idx <= next_active;
        end
    end

    // Serial output frame: loaded at busy fall, shifted on each serial clock rise while the port is enabled and the converter is not busy.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shift_out <= '0;
            out_cnt   <= 5'h0;
        end else if (busy_fall) begin
            shift_out <= {conv_result, used_idx == '0, mem[used_idx]};
            out_cnt   <= 5'h0;
        end else if (sck_rise && port_en && !conv_busy) begin
            shift_out <= {shift_out[ACS_FRAME_W-2:0], 1'b0};
            if (out_cnt != 5'(ACS_FRAME_W)) begin
                out_cnt <= out_cnt + 5'h1;
            end
        end
    end

    // Registered outputs toward the mux and the host.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mux_output_pos     <= '0;
            mux_output_neg     <= '0;
            range_sel          <= 2'h0;
            gain_comp_sel      <= 1'b0;
            acquire_restart    <= 1'b0;
            sequence_head_flag <= 1'b0;
            serial_out         <= 1'b0;
        end else begin
            mux_output_pos     <= next_pos;
            mux_output_neg     <= next_neg;
            range_sel          <= cur_cfg[ACS_RANGE_HI:ACS_RANGE_LO];
            gain_comp_sel      <= cur_cfg[ACS_GAIN_BIT];
            acquire_restart    <= first_word;
            sequence_head_flag <= (used_idx == '0);
            serial_out         <= port_en & shift_out[ACS_FRAME_W-1];
        end
    end

    // Read data selection.
    wire [31:0] status_word = {14'h0, sequence_head_flag, win == ACS_WIN_OPEN,
                               4'(used_idx), 4'(active_idx), 3'h0, 5'(depth)};
    wire        rd_hit  = (s_axi_araddr == ACS_OFF_CTRL) || (s_axi_araddr == ACS_OFF_STATUS)
                          || (s_axi_araddr == ACS_OFF_CFG);
    wire [31:0] rd_data = (s_axi_araddr == ACS_OFF_CTRL)   ? {31'h0, port_en} :
                          (s_axi_araddr == ACS_OFF_STATUS) ? status_word :
                          (s_axi_araddr == ACS_OFF_CFG)    ? {25'h0, cur_cfg} : 32'h0;
    wire        wr_both = aw_got & w_got & ~s_axi_bvalid;

    // Write channel: address and data accepted in either order.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got <= 1'b0;
            w_got  <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= ACS_RESP_OKAY;
            aw_addr <= '0;
            w_data  <= 32'h0;
            w_strb  <= 4'h0;
            port_en <= ACS_CTRL_RESET;
        end else begin
            s_axi_awready <= ~aw_got & ~(s_axi_awvalid & s_axi_awready);
            s_axi_wready  <= ~w_got & ~(s_axi_wvalid & s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got  <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got  <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_both) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr == ACS_OFF_CTRL || aw_addr == ACS_OFF_STATUS
                                 || aw_addr == ACS_OFF_CFG) ? ACS_RESP_OKAY : ACS_RESP_SLVERR;
                if (aw_addr == ACS_OFF_CTRL && w_strb[0]) begin
                    port_en <= w_data[ACS_CTRL_PORT_EN];
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_got <= 1'b0;
                w_got  <= 1'b0;
            end
        end
    end

    // Read channel.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= ACS_RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_data;
                s_axi_rresp  <= rd_hit ? ACS_RESP_OKAY : ACS_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Checks on window, memory, pointer, serial flag and mux output behaviour.
    a_reset_defaults: assert property (@(posedge aclk) !aresetn |=>
        depth == 1 && mem[0] == 7'h00 && win == ACS_WIN_OPEN)
        else $error("reset did not restore defaults");
    a_busy_closes: assert property (@(posedge aclk) disable iff (!aresetn)
        busy_rise |=> win == ACS_WIN_CLOSED && bit_cnt == 3'h0)
        else $error("window still open after busy rose");
    a_busy_opens: assert property (@(posedge aclk) disable iff (!aresetn)
        busy_fall |=> win == ACS_WIN_OPEN && written == '0)
        else $error("window not opened at busy fall");
    a_busy_ignores: assert property (@(posedge aclk) disable iff (!aresetn)
        conv_busy && !busy_fall |=> $stable(shift_in) && $stable(depth))
        else $error("serial input taken while busy");
    a_first_word: assert property (@(posedge aclk) disable iff (!aresetn)
        first_word && !busy_fall |=> depth == 1 && active_idx == '0 && acquire_restart
        ##1 mux_output_pos == $past(next_pos))
        else $error("first word not applied at once");
    a_msb_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        msb_zero && !busy_fall |=> (win == ACS_WIN_CLOSED) throughout (!busy_fall [*3]))
        else $error("zero MSB did not close the window");
    a_full_close: assert property (@(posedge aclk) disable iff (!aresetn)
        mem_full && !busy_fall |=> win == ACS_WIN_CLOSED && depth == SEQ_DEPTH)
        else $error("window open after memory filled");
    a_ptr_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
        busy_rise && !word_done && active_idx == last_idx |=> active_idx == '0)
        else $error("pointer did not wrap after last entry");
    a_ptr_step: assert property (@(posedge aclk) disable iff (!aresetn)
        busy_rise && !word_done && active_idx != last_idx |=> active_idx == $past(active_idx) + 1)
        else $error("pointer did not advance by one");
    a_head_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        sck_rise && port_en && !conv_busy && !busy_fall && out_cnt == ACS_FLAG_EDGE - 1
        |=> ##1 serial_out == (used_idx == '0))
        else $error("head flag missing on the 17th cycle");
    a_mux_onehot: assert property (@(posedge aclk) disable iff (!aresetn)
        mux_code[3] |=> mux_output_neg == (ACS_SEL_W'(1) << ACS_COM_IDX)
        && $onehot(mux_output_pos))
        else $error("single-ended code not against common");
endmodule

// *** acs_pkg.sv ***
/*
 * Shared constants for the converter configuration sequencer: register map,
 * configuration word layout, serial frame positions and reset values.
 * Assumes a 32-bit AXI4-Lite register bus and an 8-input mux plus common input.
 */
package acs_pkg;
    // Register byte offsets.
    localparam logic [3:0] ACS_OFF_CTRL   = 4'h0;
    localparam logic [3:0] ACS_OFF_STATUS = 4'h4;
    localparam logic [3:0] ACS_OFF_CFG    = 4'h8;
    localparam int         ACS_ADDR_W     = 4;

    // Control register fields and reset value.
    localparam int         ACS_CTRL_PORT_EN = 0;
    localparam logic [0:0] ACS_CTRL_RESET   = 1'h1;

    // Status register field positions.
    localparam int ACS_ST_DEPTH   = 0;
    localparam int ACS_ST_ACTIVE  = 8;
    localparam int ACS_ST_USED    = 12;
    localparam int ACS_ST_WINDOW  = 16;
    localparam int ACS_ST_HEAD    = 17;

    // Configuration word layout.
    localparam int ACS_WORD_W    = 8;
    localparam int ACS_CFG_W     = 7;
    localparam int ACS_VALID_BIT = 7;
    localparam int ACS_MUX_HI    = 6;
    localparam int ACS_MUX_LO    = 3;
    localparam int ACS_RANGE_HI  = 2;
    localparam int ACS_RANGE_LO  = 1;
    localparam int ACS_GAIN_BIT  = 0;
    localparam logic [6:0] ACS_CFG_RESET = 7'h00;

    // Mux output select width: eight inputs plus the common input.
    localparam int         ACS_SEL_W   = 9;
    localparam logic [3:0] ACS_COM_IDX = 4'h8;

    // Serial frame: result bits, then the head flag, then the used word.
    localparam int         ACS_RESULT_W = 16;
    localparam int         ACS_FRAME_W  = 24;
    localparam logic [4:0] ACS_FLAG_EDGE = 5'h10;

    // Bus responses.
    localparam logic [1:0] ACS_RESP_OKAY   = 2'h0;
    localparam logic [1:0] ACS_RESP_SLVERR = 2'h2;

    typedef enum logic {ACS_WIN_OPEN, ACS_WIN_CLOSED} acs_win_t;
endpackage

// *** acs_host_model.sv ***
/* Host side of the serial port: shifts bytes in MSB first and collects the
 * returned frame. Assumes the bench places each frame inside one window. */
`timescale 1ns/1ns
module acs_host_model (
    output logic      serial_clock,
    output logic      serial_in,
    input  wire logic serial_out
);
    int half_ns = 16;

    // The serial clock idles low between frames.
    initial begin
        serial_clock = 1'b0;
        serial_in = 1'b0;
    end

    // Shifts the top n bits of a byte, one per rising edge, reading each
    // returned bit just before that edge.
    task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            serial_in = tx[i];
            #(half_ns);
            rx[i] = serial_out;
            serial_clock = 1'b1;
            #(half_ns);
            serial_clock = 1'b0;
        end
        // A released line shows the inverse of its last level.
        serial_in = ~serial_in;
    endtask
endmodule

// *** tb_adc_config_sequencer.sv ***
/* Bench for acs_sequencer: mux code table, then sequencing, refusals, fill,
 * registers and reset. Assumes acs_host_model drives the serial pins. */
`timescale 1ns/1ns
`define CHK(what, exp, got) begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
        err_total++; \
        $display("MISMATCH %s exp %0h got %0h", what, exp, got); \
    end \
end
module tb_adc_config_sequencer
    import acs_pkg::*;
;
    typedef struct packed {
        logic [6:0] cfg;
        logic [8:0] pos;
        logic [8:0] neg;
    } acs_row_t;
    // Each mux code with its one-hot selections; range and gain ride along.
    localparam acs_row_t rows [16] = '{
        '{7'h00, 9'h001, 9'h002}, '{7'h0A, 9'h004, 9'h008}, '{7'h14, 9'h010, 9'h020},
        '{7'h1E, 9'h040, 9'h080}, '{7'h21, 9'h002, 9'h001}, '{7'h2B, 9'h008, 9'h004},
        '{7'h35, 9'h020, 9'h010}, '{7'h3F, 9'h080, 9'h040}, '{7'h40, 9'h001, 9'h100},
        '{7'h4A, 9'h002, 9'h100}, '{7'h54, 9'h004, 9'h100}, '{7'h5E, 9'h008, 9'h100},
        '{7'h61, 9'h010, 9'h100}, '{7'h6B, 9'h020, 9'h100}, '{7'h75, 9'h040, 9'h100},
        '{7'h7F, 9'h080, 9'h100}};
    localparam int seq [3] = '{7, 9, 12};
    logic        aresetn = 1'b0, conv_busy = 1'b0, s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [15:0] conv_result = 16'h0;
    logic        aclk, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, serial_clock, serial_in, serial_out, gain_comp_sel;
    logic        acquire_restart, sequence_head_flag;
    logic [31:0] s_axi_rdata, rd;
    logic [1:0]  s_axi_bresp, s_axi_rresp, range_sel, rsp;
    logic [8:0]  mux_output_pos, mux_output_neg;
    logic [6:0]  prev;
    logic [7:0]  txq[$], rxq[$];
    int          err_total = 0, n_checks = 0, n_restart = 0, base;

    acs_sequencer i_dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_clock, .serial_in,
        .serial_out, .conv_busy, .conv_result, .mux_output_pos, .mux_output_neg,
        .range_sel, .gain_comp_sel, .acquire_restart, .sequence_head_flag
    );
    acs_host_model u_host (.serial_clock, .serial_in, .serial_out);

    // Bus clock, and a count of restart pulses.
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        if (acquire_restart === 1'b1) begin
            n_restart <= n_restart + 1;
        end
    end

    // Waits one clock; a wait that runs too long ends the run.
    task automatic step(inout int t);
        @(posedge aclk);
        t++;
        if (t > 400) begin
            err_total++;
            $display("MISMATCH bus answer exp 1 got 0");
            give_verdict();
        end
    endtask

    // Write: address and data offered together, each dropped once taken.
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        int t;
        t = 0;
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            step(t);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    // Read: the answer lands in rd and rsp.
    task automatic axi_rd(input logic [3:0] a);
        int t;
        t = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            step(t);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // One conversion; the result is handed over at the busy fall.
    task automatic convert(input logic [15:0] res);
        conv_busy <= 1'b1;
        repeat (20) @(posedge aclk);
        conv_result <= res;
        conv_busy <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask

    // Sends the queued bytes as one frame, out of phase with the bus clock.
    task automatic frame(input int last_bits);
        logic [7:0] rx;
        rxq = {};
        #3;
        foreach (txq[i]) begin
            u_host.xfer(txq[i], (i == txq.size() - 1) ? last_bits : 8, rx);
            rxq.push_back(rx);
        end
        repeat (13) @(posedge aclk);
    endtask

    // Converts, then reads the frame back and checks the entry it used.
    task automatic conv_used(input logic [6:0] cfg, input logic head, input logic [7:0] mid);
        convert(16'h0000);
        txq = '{8'h00, mid, 8'h00};
        frame(8);
        `CHK("used word", {head, cfg}, rxq[2])
        `CHK("sequence_head_flag", head, sequence_head_flag)
    endtask

    // State expected after any reset.
    task automatic check_reset();
        `CHK("mux_output_pos", 9'h001, mux_output_pos)
        `CHK("mux_output_neg", 9'h002, mux_output_neg)
        axi_rd(ACS_OFF_STATUS);
        `CHK("depth", 5'h01, rd[4:0])
        `CHK("window", 1'b1, rd[ACS_ST_WINDOW])
        axi_rd(ACS_OFF_CFG);
        `CHK("cfg", 32'h0, rd)
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Reset, the code table, then the hand-written cases.
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        check_reset();
        $display("test reset done");
        prev = 7'h00;
        foreach (rows[i]) begin
            base = n_restart;
            convert(16'hA5C3 ^ 16'(i));
            txq = '{{1'b1, rows[i].cfg}, 8'h00, 8'h00};
            frame(8);
            `CHK("result", 16'hA5C3 ^ 16'(i), {rxq[0], rxq[1]})
            `CHK("head bit", 1'b1, rxq[2][7])
            `CHK("used word", prev, rxq[2][6:0])
            `CHK("mux_output_pos", rows[i].pos, mux_output_pos)
            `CHK("mux_output_neg", rows[i].neg, mux_output_neg)
            `CHK("range_sel", rows[i].cfg[2:1], range_sel)
            `CHK("gain_comp_sel", rows[i].cfg[0], gain_comp_sel)
            `CHK("restart", base + 1, n_restart)
            prev = rows[i].cfg;
        end
        $display("test mux table done");
        base = n_restart;
        convert(16'h1234);
        u_host.half_ns = 40;
        txq = '{{1'b1, rows[7].cfg}, {1'b1, rows[9].cfg}, {1'b1, rows[12].cfg}};
        frame(8);
        u_host.half_ns = 16;
        `CHK("restart", base + 1, n_restart)
        `CHK("mux_output_pos", rows[7].pos, mux_output_pos)
        axi_rd(ACS_OFF_STATUS);
        `CHK("depth", 5'h03, rd[4:0])
        for (int k = 0; k < 4; k++) begin
            conv_used(rows[seq[k % 3]].cfg, k % 3 == 0, 8'h00);
        end
        $display("test sequence done");
        base = n_restart;
        conv_busy <= 1'b1;
        txq = '{8'hC0};
        frame(8);
        conv_busy <= 1'b0;
        repeat (4) @(posedge aclk);
        `CHK("restart", base, n_restart)
        txq = '{{1'b1, rows[0].cfg}};
        frame(5);
        conv_used(rows[12].cfg, 1'b0, {1'b1, rows[0].cfg});
        conv_used(rows[7].cfg, 1'b1, 8'h00);
        `CHK("restart", base, n_restart)
        $display("test refusals done");
        convert(16'h0F0F);
        txq = {};
        foreach (rows[i]) txq.push_back({1'b1, rows[i].cfg});
        txq.push_back(8'hD5);
        frame(8);
        axi_rd(ACS_OFF_STATUS);
        `CHK("depth", 5'h10, rd[4:0])
        `CHK("restart", base + 1, n_restart)
        for (int k = 0; k < 17; k++) begin
            conv_used(rows[k % 16].cfg, k % 16 == 0, 8'h00);
        end
        $display("test fill done");
        base = n_restart;
        axi_wr(ACS_OFF_CTRL, 32'h0);
        convert(16'h0000);
        txq = '{{1'b1, rows[3].cfg}};
        frame(8);
        `CHK("restart", base, n_restart)
        axi_wr(ACS_OFF_CTRL, 32'h1);
        axi_rd(ACS_OFF_CTRL);
        `CHK("ctrl", 32'h1, rd)
        axi_rd(4'hC);
        `CHK("rresp", ACS_RESP_SLVERR, rsp)
        axi_wr(4'hC, 32'hFFFF_FFFF);
        `CHK("bresp", ACS_RESP_SLVERR, rsp)
        conv_used(rows[2].cfg, 1'b0, 8'h00);
        $display("test registers done");
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        check_reset();
        $display("test second reset done");
        give_verdict();
    end
endmodule
